//--- rtl/ssia_arbiter.sv
// stop and interrupt arbiter with apb register slave
//
// Summary of operation
// - servo-on dropped while turning aborts and stops per servo-off action; immediate uses third limit
// - servo-off action free-run removes torque so the motor coasts
// - third-limit stops use forward or reverse limit when that is smaller
// - open nc overtravel or software overtravel while turning stops at third limit
// - overtravel during homing stops per homing overtravel action instead
// - forced stop while turning aborts with immediate third-limit stop
// - while forced stop holds, keep zero speed and discard position
// - forced stop on external inputs one to six is normally closed
// - pause halts listed positioning operations, resumes them on release
// - in-position stays low throughout a pause
// - pause and cancel ramps come from time sets by select input or entry data
// - positioning cancel while turning aborts with controlled deceleration
// - while cancel holds, positioning starts are refused; also acts in speed and pulse
// - deviation clear while turning stops immediately at selected torque limit
// - level deviation clear holds zero speed and discards position while active
// - free-run switches power outputs off; during rotation aborts and coasts
// - alarm stops per alarm action; serious alarms always free-run
// - target beyond soft limiter is cut to limiter position
// - limiter flag rises only after motor stops at limiter
// - pulse operation stops at limiter using configured torque limit
// - enabled at power-on by first/25th function equal one, or none one and first zero
// - restart-required settings take effect only at next power-up or on a restart command
// - deviation clear is edge or level by input form setting
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "ssia_cfg.svh"
module ssia_arbiter #(
	parameter int POS_W = 32,
	parameter int TQ_W = 16
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic servo_on,
	input wire logic positive_overtravel_n,
	input wire logic negative_overtravel_n,
	input wire logic soft_overtravel_pos,
	input wire logic soft_overtravel_neg,
	input wire logic forced_stop_input,
	input wire logic pause,
	input wire logic position_cancel,
	input wire logic deviation_clear,
	input wire logic free_run,
	input wire logic alarm,
	input wire logic alarm_serious,
	input wire logic accel_set_select,
	input wire logic motor_moving,
	input wire ssia_pkg::ssia_op_e op_kind,
	input wire logic start_req,
	input wire logic entry_time_valid,
	input wire logic [15:0] entry_accel_time,
	input wire logic [15:0] entry_decel_time,
	input wire logic signed [POS_W-1:0] target_pos,
	input wire logic signed [POS_W-1:0] pulse_cmd_pos,
	input wire logic zero_deviation,
	output ssia_pkg::ssia_stop_e stop_mode,
	output logic abort_op,
	output logic power_stage_off,
	output logic hold_zero_speed,
	output logic discard_position,
	output logic [TQ_W-1:0] fwd_torque_out,
	output logic [TQ_W-1:0] rev_torque_out,
	output logic [15:0] accel_time_out,
	output logic [15:0] decel_time_out,
	output logic start_allow,
	output logic resume_op,
	output logic in_position_output,
	output logic signed [POS_W-1:0] target_out,
	output logic pos_limit_flag,
	output logic neg_limit_flag,
	output logic servo_enabled
);
	import ssia_pkg::*;

	if (POS_W < 8 || POS_W > 32 || TQ_W < 8 || TQ_W > 16) begin : g_chk
		$error("ssia_arbiter: POS_W must be 8..32 and TQ_W 8..16");
	end

	// configuration registers
	logic [1:0] soa_reg;
	logic [1:0] ala_reg;
	logic [1:0] hoa_reg;
	logic dcf_reg;
	logic [2:0] fs_slot_reg;
	logic [TQ_W-1:0] fwd_reg;
	logic [TQ_W-1:0] rev_reg;
	logic [TQ_W-1:0] third_reg;
	logic [15:0] acc1_reg;
	logic [15:0] acc2_reg;
	logic [15:0] dec1_reg;
	logic [15:0] dec2_reg;
	logic [16:0] func_reg;
	logic [16:0] func_act_reg;
	logic signed [POS_W-1:0] plim_reg;
	logic signed [POS_W-1:0] nlim_reg;
	logic restart;

	ssia_state_e state_reg;
	ssia_stop_e req;
	logic req_third;
	logic req_abort;
	logic use_third_reg;
	logic pause_hold_reg;
	logic dc_q_reg;
	logic lim_pend_pos_reg;
	logic lim_pend_neg_reg;
	logic moved_reg;

	logic wr_en;
	logic rd_en;
	logic hit;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	assign pready = psel & penable;
	always_comb begin
		unique case (paddr)
			`SSIA_OFF_CTRL, `SSIA_OFF_TORQ, `SSIA_OFF_THIRD, `SSIA_OFF_ACCEL, `SSIA_OFF_DECEL,
			`SSIA_OFF_FUNC, `SSIA_OFF_PLIM, `SSIA_OFF_NLIM, `SSIA_OFF_STAT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	// unmapped addresses and writes to status answer with an error
	assign pslverr = pready & (~hit | (pwrite & (paddr == `SSIA_OFF_STAT)));
	assign restart = wr_en & (paddr == `SSIA_OFF_CTRL) & pwdata[`SSIA_CTRL_RST_BIT];

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			soa_reg <= 2'h0;
			ala_reg <= 2'h0;
			hoa_reg <= 2'h0;
			dcf_reg <= 1'b0;
			fs_slot_reg <= 3'h0;
			fwd_reg <= TQ_W'(`SSIA_RST_TORQ);
			rev_reg <= TQ_W'(`SSIA_RST_TORQ);
			third_reg <= TQ_W'(`SSIA_RST_THIRD);
			acc1_reg <= `SSIA_RST_T1;
			dec1_reg <= `SSIA_RST_T1;
			acc2_reg <= `SSIA_RST_T2;
			dec2_reg <= `SSIA_RST_T2;
			func_reg <= `SSIA_RST_FUNC;
			plim_reg <= POS_W'(`SSIA_RST_PLIM >>> (32 - POS_W));
			nlim_reg <= POS_W'($signed(`SSIA_RST_NLIM) >>> (32 - POS_W));
		end else if (wr_en) begin
			unique case (paddr)
				`SSIA_OFF_CTRL: begin
					soa_reg <= pwdata[`SSIA_CTRL_SOA_LSB +: 2];
					ala_reg <= pwdata[`SSIA_CTRL_ALA_LSB +: 2];
					hoa_reg <= pwdata[`SSIA_CTRL_HOA_LSB +: 2];
					dcf_reg <= pwdata[`SSIA_CTRL_DCF_BIT];
					fs_slot_reg <= pwdata[`SSIA_CTRL_FSS_LSB +: 3];
				end
				`SSIA_OFF_TORQ: begin
					fwd_reg <= pwdata[TQ_W-1:0];
					rev_reg <= pwdata[16 +: TQ_W];
				end
				`SSIA_OFF_THIRD: third_reg <= pwdata[TQ_W-1:0];
				`SSIA_OFF_ACCEL: begin
					acc1_reg <= pwdata[15:0];
					acc2_reg <= pwdata[31:16];
				end
				`SSIA_OFF_DECEL: begin
					dec1_reg <= pwdata[15:0];
					dec2_reg <= pwdata[31:16];
				end
				`SSIA_OFF_FUNC: func_reg <= pwdata[16:0];
				`SSIA_OFF_PLIM: plim_reg <= pwdata[POS_W-1:0];
				`SSIA_OFF_NLIM: nlim_reg <= pwdata[POS_W-1:0];
				default: ;
			endcase
		end
	end

	// function settings only apply at power-up or on a restart command
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			func_act_reg <= `SSIA_RST_FUNC;
		end else if (restart) begin
			func_act_reg <= func_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			servo_enabled <= 1'b0;
		end else begin
			servo_enabled <= (func_act_reg[7:0] == `SSIA_FUNC_ONE
				&& func_act_reg[`SSIA_FUNC_F25_LSB +: 8] == `SSIA_FUNC_ONE)
				|| (!func_act_reg[`SSIA_FUNC_MID_BIT] && func_act_reg[7:0] == `SSIA_FUNC_ZERO);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			unique case (paddr)
				`SSIA_OFF_CTRL: prdata <= {21'h0, fs_slot_reg, 1'b0, dcf_reg, hoa_reg, ala_reg, soa_reg};
				`SSIA_OFF_TORQ: prdata <= {16'(rev_reg), 16'(fwd_reg)};
				`SSIA_OFF_THIRD: prdata <= 32'(third_reg);
				`SSIA_OFF_ACCEL: prdata <= {acc2_reg, acc1_reg};
				`SSIA_OFF_DECEL: prdata <= {dec2_reg, dec1_reg};
				`SSIA_OFF_FUNC: prdata <= {15'h0, func_reg};
				`SSIA_OFF_PLIM: prdata <= 32'(plim_reg);
				`SSIA_OFF_NLIM: prdata <= 32'(nlim_reg);
				`SSIA_OFF_STAT: prdata <= {22'h0, servo_enabled, start_allow, pause_hold_reg,
					neg_limit_flag, pos_limit_flag, in_position_output, power_stage_off, stop_mode, 1'b0};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// stop cause evaluation
	function automatic ssia_stop_e act2mode(input logic [1:0] a);
		case (a)
			2'h1: return STOP_IMMED;
			2'h2: return STOP_COAST;
			default: return STOP_DECEL;
		endcase
	endfunction : act2mode

	function automatic ssia_stop_e smax(input ssia_stop_e a, input ssia_stop_e b);
		return (a > b) ? a : b;
	endfunction : smax

	logic fs_act;
	logic ot_act;
	logic dc_trig;
	logic dc_hold;
	logic pos_op;
	logic pulse_lim;
	ssia_stop_e m;
	// a forced stop wired to an external input slot is fail-safe: open means stop
	assign fs_act = (fs_slot_reg >= `SSIA_FS_SLOT_LO && fs_slot_reg <= `SSIA_FS_SLOT_HI)
		? ~forced_stop_input : forced_stop_input;
	assign ot_act = ~positive_overtravel_n | ~negative_overtravel_n
		| soft_overtravel_pos | soft_overtravel_neg;
	assign dc_trig = dcf_reg ? deviation_clear : (deviation_clear & ~dc_q_reg);
	assign dc_hold = dcf_reg & deviation_clear;
	assign pos_op = op_kind inside {OP_HOMING, OP_INTERRUPT, OP_STORED, OP_IMMEDIATE};
	assign pulse_lim = (op_kind == OP_PULSE) & motor_moving
		& (pulse_cmd_pos >= plim_reg | pulse_cmd_pos <= nlim_reg);

	always_comb begin
		req = STOP_NONE;
		req_third = 1'b0;
		req_abort = 1'b0;
		m = STOP_NONE;
		if (!servo_on && motor_moving) begin
			m = act2mode(soa_reg);
			req = smax(req, m);
			req_third = req_third | (m == STOP_IMMED);
			req_abort = 1'b1;
		end
		if (ot_act && motor_moving) begin
			m = (op_kind == OP_HOMING) ? act2mode(hoa_reg) : STOP_IMMED;
			req = smax(req, m);
			req_third = req_third | (m == STOP_IMMED);
			req_abort = 1'b1;
		end
		if (fs_act) begin
			req = smax(req, STOP_IMMED);
			req_third = 1'b1;
			req_abort = req_abort | motor_moving;
		end
		if ((dc_trig && motor_moving) || dc_hold || pulse_lim) begin
			req = smax(req, STOP_IMMED);
			req_abort = req_abort | motor_moving;
		end
		if (position_cancel && motor_moving) begin
			req = smax(req, STOP_DECEL);
			req_abort = 1'b1;
		end
		if (pause_hold_reg) begin
			req = smax(req, STOP_DECEL);
		end
		if (alarm) begin
			m = alarm_serious ? STOP_COAST : act2mode(ala_reg);
			req = smax(req, m);
			req_third = req_third | (m == STOP_IMMED);
			req_abort = 1'b1;
		end
		if (free_run) begin
			req = STOP_COAST;
			req_abort = req_abort | motor_moving;
		end
	end

	// a stop persists until the motor is at rest and no cause remains
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			stop_mode <= STOP_NONE;
			use_third_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (req != STOP_NONE) begin
						state_reg <= ST_STOPPING;
					end
					stop_mode <= req;
					use_third_reg <= req_third;
				end
				ST_STOPPING: begin
					if (!motor_moving && req == STOP_NONE) begin
						state_reg <= ST_IDLE;
						stop_mode <= STOP_NONE;
						use_third_reg <= 1'b0;
					end else begin
						stop_mode <= smax(req, stop_mode);
						use_third_reg <= use_third_reg | req_third;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			abort_op <= 1'b0;
		end else begin
			abort_op <= (state_reg == ST_IDLE) & req_abort;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			power_stage_off <= 1'b0;
			hold_zero_speed <= 1'b0;
			discard_position <= 1'b0;
			dc_q_reg <= 1'b0;
		end else begin
			power_stage_off <= free_run | (alarm & alarm_serious)
				| (smax(req, stop_mode) == STOP_COAST);
			hold_zero_speed <= fs_act | dc_hold;
			discard_position <= fs_act | dc_hold;
			dc_q_reg <= deviation_clear;
		end
	end

	// torque limits: a third-limit stop never exceeds the forward or reverse limit
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			fwd_torque_out <= TQ_W'(`SSIA_RST_TORQ);
			rev_torque_out <= TQ_W'(`SSIA_RST_TORQ);
		end else if (req_third || use_third_reg) begin
			fwd_torque_out <= (fwd_reg < third_reg) ? fwd_reg : third_reg;
			rev_torque_out <= (rev_reg < third_reg) ? rev_reg : third_reg;
		end else begin
			fwd_torque_out <= fwd_reg;
			rev_torque_out <= rev_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			accel_time_out <= `SSIA_RST_T1;
			decel_time_out <= `SSIA_RST_T1;
		end else if (entry_time_valid) begin
			accel_time_out <= entry_accel_time;
			decel_time_out <= entry_decel_time;
		end else begin
			accel_time_out <= accel_set_select ? acc2_reg : acc1_reg;
			decel_time_out <= accel_set_select ? dec2_reg : dec1_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pause_hold_reg <= 1'b0;
			resume_op <= 1'b0;
		end else begin
			pause_hold_reg <= pause & (pos_op | pause_hold_reg);
			resume_op <= pause_hold_reg & ~pause;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			start_allow <= 1'b0;
			in_position_output <= 1'b0;
		end else begin
			start_allow <= servo_enabled & ~position_cancel & ~fs_act;
			in_position_output <= zero_deviation & ~motor_moving & ~pause & ~pause_hold_reg
				& (state_reg == ST_IDLE);
		end
	end

	// soft limiter: the target is cut at the limiter, the flag follows once at rest
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			target_out <= '0;
			lim_pend_pos_reg <= 1'b0;
			lim_pend_neg_reg <= 1'b0;
			moved_reg <= 1'b0;
		end else if (start_req) begin
			target_out <= (target_pos > plim_reg) ? plim_reg
				: (target_pos < nlim_reg) ? nlim_reg : target_pos;
			lim_pend_pos_reg <= target_pos > plim_reg;
			lim_pend_neg_reg <= target_pos < nlim_reg;
			moved_reg <= 1'b0;
		end else begin
			if (pulse_lim) begin
				lim_pend_pos_reg <= lim_pend_pos_reg | (pulse_cmd_pos >= plim_reg);
				lim_pend_neg_reg <= lim_pend_neg_reg | (pulse_cmd_pos <= nlim_reg);
			end else if (!motor_moving && moved_reg) begin
				lim_pend_pos_reg <= 1'b0;
				lim_pend_neg_reg <= 1'b0;
			end
			moved_reg <= (moved_reg | motor_moving) & (lim_pend_pos_reg | lim_pend_neg_reg | pulse_lim);
		end
	end

	// set wins over the clear by a new start
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pos_limit_flag <= 1'b0;
			neg_limit_flag <= 1'b0;
		end else begin
			pos_limit_flag <= (lim_pend_pos_reg & moved_reg & ~motor_moving)
				| (pos_limit_flag & ~start_req);
			neg_limit_flag <= (lim_pend_neg_reg & moved_reg & ~motor_moving)
				| (neg_limit_flag & ~start_req);
		end
	end

	property p_free_run_coast;
		@(posedge sys_clk) disable iff (sys_rst) free_run |=> power_stage_off && stop_mode == STOP_COAST;
	endproperty
	a_free_run_coast: assert property (p_free_run_coast) else $error("free-run did not coast");

	property p_serious_alarm;
		@(posedge sys_clk) disable iff (sys_rst) alarm && alarm_serious |=> power_stage_off;
	endproperty
	a_serious_alarm: assert property (p_serious_alarm) else $error("serious alarm not free-run");

	property p_forced_hold;
		@(posedge sys_clk) disable iff (sys_rst) fs_act |=> hold_zero_speed && discard_position;
	endproperty
	a_forced_hold: assert property (p_forced_hold) else $error("forced stop not held");

	property p_forced_immed;
		@(posedge sys_clk) disable iff (sys_rst) fs_act && !free_run && !alarm
			|=> stop_mode == STOP_IMMED || stop_mode == STOP_COAST;
	endproperty
	a_forced_immed: assert property (p_forced_immed) else $error("forced stop not immediate");

	property p_pause_no_inpos;
		@(posedge sys_clk) disable iff (sys_rst) pause_hold_reg |=> !in_position_output;
	endproperty
	a_pause_no_inpos: assert property (p_pause_no_inpos) else $error("in-position during pause");

	property p_cancel_refuse;
		@(posedge sys_clk) disable iff (sys_rst) position_cancel |=> !start_allow;
	endproperty
	a_cancel_refuse: assert property (p_cancel_refuse) else $error("start allowed under cancel");

	property p_third_min;
		@(posedge sys_clk) disable iff (sys_rst) req_third
			|=> fwd_torque_out <= $past(third_reg) && fwd_torque_out <= $past(fwd_reg);
	endproperty
	a_third_min: assert property (p_third_min) else $error("torque above a limit");

	property p_soft_clamp;
		@(posedge sys_clk) disable iff (sys_rst) start_req && target_pos > plim_reg
			|=> target_out == $past(plim_reg);
	endproperty
	a_soft_clamp: assert property (p_soft_clamp) else $error("target not cut at limiter");

	property p_flag_at_rest;
		@(posedge sys_clk) disable iff (sys_rst) $rose(pos_limit_flag) |-> !$past(motor_moving);
	endproperty
	a_flag_at_rest: assert property (p_flag_at_rest) else $error("limiter flag while moving");

	property p_level_dc;
		@(posedge sys_clk) disable iff (sys_rst) dcf_reg && deviation_clear |=> hold_zero_speed;
	endproperty
	a_level_dc: assert property (p_level_dc) else $error("level deviation clear not held");

	property p_pause_resume;
		@(posedge sys_clk) disable iff (sys_rst) pause_hold_reg && !pause |=> resume_op ##1 !resume_op;
	endproperty
	a_pause_resume: assert property (p_pause_resume) else $error("resume pulse wrong");

endmodule : ssia_arbiter

//--- rtl/ssia_cfg.svh
// register map, field positions and reset values of the stop and interrupt arbiter
`ifndef SSIA_CFG_SVH
`define SSIA_CFG_SVH
`define SSIA_OFF_CTRL 8'h00
`define SSIA_OFF_TORQ 8'h04
`define SSIA_OFF_THIRD 8'h08
`define SSIA_OFF_ACCEL 8'h0C
`define SSIA_OFF_DECEL 8'h10
`define SSIA_OFF_FUNC 8'h14
`define SSIA_OFF_PLIM 8'h18
`define SSIA_OFF_NLIM 8'h1C
`define SSIA_OFF_STAT 8'h20
`define SSIA_CTRL_SOA_LSB 0
`define SSIA_CTRL_ALA_LSB 2
`define SSIA_CTRL_HOA_LSB 4
`define SSIA_CTRL_DCF_BIT 6
`define SSIA_CTRL_FSS_LSB 8
`define SSIA_CTRL_RST_BIT 16
`define SSIA_FUNC_F25_LSB 8
`define SSIA_FUNC_MID_BIT 16
`define SSIA_FS_SLOT_LO 3'h1
`define SSIA_FS_SLOT_HI 3'h6
`define SSIA_RST_CTRL 32'h0000_0000
`define SSIA_RST_TORQ 16'h012C
`define SSIA_RST_THIRD 16'h012C
`define SSIA_RST_T1 16'h03E8
`define SSIA_RST_T2 16'h1388
`define SSIA_RST_FUNC 17'h0_0000
`define SSIA_RST_PLIM 32'h7FFF_FFFF
`define SSIA_RST_NLIM 32'h8000_0000
`define SSIA_FUNC_ONE 8'h01
`define SSIA_FUNC_ZERO 8'h00
`endif

//--- rtl/ssia_pkg.sv
// types shared by the stop and interrupt arbiter
package ssia_pkg;
	// declaration order is severity order
	typedef enum logic [1:0] {STOP_NONE, STOP_DECEL, STOP_IMMED, STOP_COAST} ssia_stop_e;
	typedef enum logic [2:0] {OP_IDLE, OP_HOMING, OP_INTERRUPT, OP_STORED, OP_IMMEDIATE, OP_SPEED,
		OP_PULSE} ssia_op_e;
	typedef enum logic {ST_IDLE, ST_STOPPING} ssia_state_e;
endpackage : ssia_pkg

//--- verification/ssia_motor_model.sv
// motor and power stage model: runs on command, comes to rest under any stop
`timescale 1ns/1ps
module ssia_motor_model #(
	parameter int DEC_CYC = 12,
	parameter int IMM_CYC = 6,
	parameter int COAST_CYC = 20
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic run_cmd,
	input wire ssia_pkg::ssia_stop_e stop_mode,
	input wire logic power_stage_off,
	output logic motor_moving
);
	import ssia_pkg::*;
	int cnt_reg;
	int cnt_next;
	// a harsher stop arriving mid-stop only shortens the remaining run, never lengthens it
	always_comb begin
		cnt_next = power_stage_off ? COAST_CYC : (stop_mode == STOP_IMMED ? IMM_CYC : DEC_CYC);
		if (cnt_reg - 1 < cnt_next) begin
			cnt_next = cnt_reg - 1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			motor_moving <= 1'b0;
			cnt_reg <= 0;
		end else if (run_cmd && stop_mode == STOP_NONE) begin
			motor_moving <= 1'b1;
			cnt_reg <= COAST_CYC;
		end else if (motor_moving && (stop_mode != STOP_NONE || power_stage_off)) begin
			cnt_reg <= cnt_next;
			if (cnt_reg <= 1) begin
				motor_moving <= 1'b0;
			end
		end
	end
endmodule : ssia_motor_model

//--- verification/servo_stop_interrupt_arbiter_tb.sv
// self-checking bench for the stop and interrupt arbiter
`timescale 1ns/1ps
`include "ssia_cfg.svh"
module servo_stop_interrupt_arbiter_tb;
	import ssia_pkg::*;
	// cause bits: 0 servo off, 1 +ot open, 2 soft neg, 3 forced raw, 4 cancel, 5 dev clr, 6 free, 7 alarm, 8 serious
	typedef struct packed {
		logic [7:0] ctrl;
		logic [2:0] op;
		logic [8:0] cause;
		logic [1:0] mode;
		logic off;
		logic [1:0] tq;
	} ssia_row_s;
	logic sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run_cmd = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [8:0] cause = 9'h000;
	logic pause = 1'b0, soft_pos = 1'b0, not_n = 1'b1, acc_sel = 1'b0, start_req = 1'b0, entry_ok = 1'b0;
	logic zero_dev = 1'b1, perr, pready, pslverr, motor_moving, abort_op, pso, hold, discard;
	logic start_allow, resume_op, in_pos, plim_flag, nlim_flag, servo_enabled;
	logic [15:0] e_acc = 16'h0123, e_dec = 16'h0456, fwd_tq, rev_tq, acc_out, dec_out;
	logic signed [31:0] target_pos = 32'sh0000_1388, pulse_pos = 32'sh0000_0000, target_out;
	ssia_op_e op_kind = OP_IDLE;
	ssia_stop_e stop_mode;
	ssia_row_s r;
	int mismatches = 0, tests_run = 0, n;
	localparam logic [7:0] RA [7] = '{`SSIA_OFF_CTRL, `SSIA_OFF_TORQ, `SSIA_OFF_THIRD, `SSIA_OFF_ACCEL,
		`SSIA_OFF_DECEL, `SSIA_OFF_PLIM, `SSIA_OFF_NLIM};
	localparam logic [31:0] RV [7] = '{32'h0000_0000, 32'h012C_012C, 32'h0000_012C, 32'h1388_03E8,
		32'h1388_03E8, 32'h7FFF_FFFF, 32'h8000_0000};
	localparam logic [31:0] FV [4] = '{32'h0000_0001, 32'h0000_0101, 32'h0001_0000, 32'h0000_0000};
	localparam ssia_row_s ROWS [15] = '{
		'{8'h00, 3'h0, 9'h001, 2'h1, 1'b0, 2'h0}, '{8'h01, 3'h0, 9'h001, 2'h2, 1'b0, 2'h1},
		'{8'h02, 3'h0, 9'h001, 2'h3, 1'b1, 2'h0}, '{8'h00, 3'h0, 9'h002, 2'h2, 1'b0, 2'h1},
		'{8'h00, 3'h0, 9'h004, 2'h2, 1'b0, 2'h1}, '{8'h00, 3'h0, 9'h008, 2'h2, 1'b0, 2'h1},
		'{8'h00, 3'h6, 9'h010, 2'h1, 1'b0, 2'h0}, '{8'h00, 3'h0, 9'h020, 2'h2, 1'b0, 2'h2},
		'{8'h00, 3'h0, 9'h040, 2'h3, 1'b1, 2'h0}, '{8'h04, 3'h0, 9'h080, 2'h2, 1'b0, 2'h0},
		'{8'h04, 3'h0, 9'h180, 2'h3, 1'b1, 2'h0}, '{8'h00, 3'h0, 9'h050, 2'h3, 1'b1, 2'h0},
		'{8'h00, 3'h0, 9'h018, 2'h2, 1'b0, 2'h1}, '{8'h00, 3'h1, 9'h002, 2'h1, 1'b0, 2'h0},
		'{8'h20, 3'h1, 9'h002, 2'h3, 1'b1, 2'h0}};
	ssia_arbiter u_dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .servo_on(!cause[0]),
		.positive_overtravel_n(!cause[1]), .negative_overtravel_n(not_n), .soft_overtravel_pos(soft_pos),
		.soft_overtravel_neg(cause[2]), .forced_stop_input(cause[3]), .pause(pause), .position_cancel(cause[4]),
		.deviation_clear(cause[5]), .free_run(cause[6]), .alarm(cause[7]), .alarm_serious(cause[8]),
		.accel_set_select(acc_sel), .motor_moving(motor_moving), .op_kind(op_kind), .start_req(start_req),
		.entry_time_valid(entry_ok), .entry_accel_time(e_acc), .entry_decel_time(e_dec), .target_pos(target_pos),
		.pulse_cmd_pos(pulse_pos), .zero_deviation(zero_dev), .stop_mode(stop_mode), .abort_op(abort_op),
		.power_stage_off(pso), .hold_zero_speed(hold), .discard_position(discard), .fwd_torque_out(fwd_tq),
		.rev_torque_out(rev_tq), .accel_time_out(acc_out), .decel_time_out(dec_out), .start_allow(start_allow),
		.resume_op(resume_op), .in_position_output(in_pos), .target_out(target_out),
		.pos_limit_flag(plim_flag), .neg_limit_flag(nlim_flag), .servo_enabled(servo_enabled));
	ssia_motor_model u_motor (.sys_clk(sys_clk), .sys_rst(sys_rst), .run_cmd(run_cmd), .stop_mode(stop_mode),
		.power_stage_off(pso), .motor_moving(motor_moving));
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tk(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask : tk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic set(input logic [8:0] c);
		@(posedge sys_clk);
		cause <= c;
	endtask : set
	task automatic run();
		@(posedge sys_clk);
		run_cmd <= 1'b1;
		@(posedge sys_clk);
		run_cmd <= 1'b0;
		tk(1);
	endtask : run
	task automatic idle();
		n = 0;
		while ((stop_mode !== STOP_NONE || motor_moving !== 1'b0) && n < 200) begin
			tk(1);
			n++;
		end
		chk(stop_mode, STOP_NONE);
	endtask : idle
	task automatic stop_test();
		if (mismatches == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	// generous bound: the whole sequence needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		tk(1);
		chk(servo_enabled, 1'b1);
		chk(fwd_tq, 16'h012C);
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, RA[i], 32'h0000_0000);
			chk(rd, RV[i]);
		end
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk(perr, 1'b1);
		apb(1'b1, `SSIA_OFF_STAT, 32'h0000_0000);
		chk(perr, 1'b1);
		apb(1'b1, `SSIA_OFF_TORQ, 32'h0064_012C);
		apb(1'b1, `SSIA_OFF_THIRD, 32'h0000_00C8);
		for (int i = 0; i < 15; i++) begin
			r = ROWS[i];
			apb(1'b1, `SSIA_OFF_CTRL, {24'h00_0000, r.ctrl});
			op_kind <= ssia_op_e'(r.op);
			run();
			chk(motor_moving, 1'b1);
			set(r.cause);
			tk(1);
			chk(stop_mode, r.mode);
			chk(abort_op, 1'b1);
			chk(pso, r.off);
			if (r.tq != 2'h0) begin
				chk(fwd_tq, r.tq == 2'h1 ? 16'h00C8 : 16'h012C);
				chk(rev_tq, 16'h0064);
			end
			set(9'h000);
			idle();
		end
		apb(1'b1, `SSIA_OFF_CTRL, 32'h0000_0000);
		op_kind <= OP_STORED;
		run();
		set(9'h010);
		set(9'h018);
		tk(1);
		chk(stop_mode, STOP_IMMED);
		set(9'h010);
		tk(2);
		chk(stop_mode, STOP_IMMED);
		set(9'h000);
		idle();
		run();
		@(posedge sys_clk);
		pause <= 1'b1;
		tk(2);
		chk(stop_mode, STOP_DECEL);
		tk(30);
		chk(in_pos, 1'b0);
		@(posedge sys_clk);
		pause <= 1'b0;
		n = 0;
		do begin
			tk(1);
			n++;
		end while (resume_op !== 1'b1 && n < 10);
		chk(resume_op, 1'b1);
		idle();
		tk(1);
		chk(in_pos, 1'b1);
		set(9'h010);
		tk(1);
		chk(start_allow, 1'b0);
		set(9'h000);
		tk(1);
		chk(start_allow, 1'b1);
		@(posedge sys_clk);
		acc_sel <= 1'b1;
		tk(1);
		chk(dec_out, 16'h1388);
		@(posedge sys_clk);
		entry_ok <= 1'b1;
		tk(1);
		chk(acc_out, 16'h0123);
		@(posedge sys_clk);
		entry_ok <= 1'b0;
		apb(1'b1, `SSIA_OFF_CTRL, 32'h0000_0300);
		tk(1);
		chk({hold, discard, start_allow}, 3'h6);
		set(9'h008);
		tk(1);
		chk(hold, 1'b0);
		apb(1'b1, `SSIA_OFF_CTRL, 32'h0000_0040);
		set(9'h020);
		tk(1);
		chk({hold, discard}, 2'h3);
		apb(1'b1, `SSIA_OFF_CTRL, 32'h0000_0000);
		tk(1);
		chk(hold, 1'b0);
		set(9'h000);
		apb(1'b1, `SSIA_OFF_PLIM, 32'h0000_03E8);
		start_req <= 1'b1;
		@(posedge sys_clk);
		start_req <= 1'b0;
		run();
		chk(target_out, 32'h0000_03E8);
		set(9'h010);
		n = 0;
		while (motor_moving === 1'b1 && n < 300) begin
			tk(1);
			n++;
		end
		chk(plim_flag, 1'b0);
		tk(2);
		chk({plim_flag, nlim_flag}, 2'h2);
		set(9'h000);
		idle();
		apb(1'b1, `SSIA_OFF_FUNC, FV[0]);
		tk(2);
		chk(servo_enabled, 1'b1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `SSIA_OFF_FUNC, FV[i]);
			apb(1'b1, `SSIA_OFF_CTRL, 32'h0001_0000);
			tk(2);
			chk(servo_enabled, i[0]);
		end
		stop_test();
	end
endmodule : servo_stop_interrupt_arbiter_tb
